/* pvcio_defines.vh */
// Purpose: constants for the vendor charger, id and io register group
// Assumes: 25 MHz interface clock, 6-bit immediate register addresses
// Notes: every offset and field position lives here, with the charger, io and id code reset values and the measurement timing
`ifndef PVCIO_DEFINES_VH
`define PVCIO_DEFINES_VH

// register addresses
`define PVCIO_ADDR_CHG 6'h32
`define PVCIO_ADDR_ID_WR 6'h36
`define PVCIO_ADDR_ID_SET 6'h37
`define PVCIO_ADDR_ID_CLR 6'h38
`define PVCIO_ADDR_IO_WR 6'h39
`define PVCIO_ADDR_IO_SET 6'h3A
`define PVCIO_ADDR_IO_CLR 6'h3B

// write operations
`define PVCIO_OP_WR 2'h0
`define PVCIO_OP_SET 2'h1
`define PVCIO_OP_CLR 2'h2

// charger control fields
`define PVCIO_CHG_SRC 0
`define PVCIO_CHG_SINK 1
`define PVCIO_CHG_CONTACT 2
`define PVCIO_CHG_HOST 3
`define PVCIO_CHG_DET 4
`define PVCIO_CHG_WMASK 8'h0F
`define PVCIO_CHG_RESET 8'h00

// id register fields
`define PVCIO_ID_CODE_HI 2
`define PVCIO_ID_CODE_LO 0
`define PVCIO_ID_DONE 3
`define PVCIO_ID_START 4
`define PVCIO_ID_IRQEN 6
`define PVCIO_ID_WMASK 8'h57
`define PVCIO_ID_CODE_RESET 3'h0

// io register fields
`define PVCIO_IO_SWAP 1
`define PVCIO_IO_UART_HI 3
`define PVCIO_IO_UART_LO 2
`define PVCIO_IO_PUP_PLUS 4
`define PVCIO_IO_PUP_MINUS 5
`define PVCIO_IO_USB_HI 7
`define PVCIO_IO_USB_LO 6
`define PVCIO_IO_WMASK 8'hFE
`define PVCIO_IO_RESET 8'h04

// misc values
`define PVCIO_LINE_SE0 2'h0
`define PVCIO_READ_ZERO 8'h00

// timing
`define PVCIO_CLK_NS 40
`define PVCIO_MEASURE_NS 282000
// one measurement in clock cycles: 282000 ns at 40 ns a cycle
`define PVCIO_MEASURE_CYCLES 16'h1B8A
`define PVCIO_CNT_W 16

`endif

/* pvcio_id_meter.v */
// Purpose: times one id pin resistance measurement
// Assumes: launch is a one-cycle pulse, abort may arrive at any time
// Notes: finish is a one-cycle pulse in the first cycle after busy drops
`timescale 1ns/1ns
`include "pvcio_defines.vh"

module pvcio_id_meter #(
   parameter [`PVCIO_CNT_W-1:0] CYCLES = `PVCIO_MEASURE_CYCLES
) (
   input wire clock,
   input wire sys_rst,
   input wire launch,
   input wire abort,
   output reg busy,
   output reg finish
);

   reg [`PVCIO_CNT_W-1:0] count_r;

   // counts down from one less than the measurement length to zero; abort drops it at once
   always @(posedge clock) begin
      if (sys_rst) begin
         busy <= 1'b0;
         finish <= 1'b0;
         count_r <= {`PVCIO_CNT_W{1'b0}};
      end else begin
         finish <= 1'b0;
         if (abort) begin
            busy <= 1'b0;
            count_r <= {`PVCIO_CNT_W{1'b0}};
         end else if (launch && !busy) begin
            busy <= 1'b1;
            count_r <= CYCLES - 16'h0001;
         end else if (busy) begin
            if (count_r == {`PVCIO_CNT_W{1'b0}}) begin
               busy <= 1'b0;
               finish <= 1'b1;
            end else begin
               count_r <= count_r - 16'h0001;
            end
         end
      end
   end

endmodule

/* pvcio_regs.v */
// Purpose: vendor charger detect, id resistance and io/power registers
// Assumes: immediate register strobes already decoded from the link framing
// Notes: analog inputs are synchronised; outputs drive analog controls
`timescale 1ns/1ns
`include "pvcio_defines.vh"

module pvcio_regs #(
   parameter [`PVCIO_CNT_W-1:0] MEASURE_CYCLES =
      `PVCIO_MEASURE_CYCLES
) (
   input wire clock,
   input wire sys_rst,
   // immediate register port
   input wire [5:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrStrobe,
   input wire regRdStrobe,
   output reg [7:0] regRdData,
   output reg regRdValid,
   // analog and mode inputs
   input wire dataDetectRaw,
   input wire [2:0] idResistorCodeRaw,
   input wire [1:0] lineState,
   input wire serialModeActive,
   input wire serialTransmitEnable,
   input wire carkitIdIrqEnable,
   // charger detect controls
   output reg plusSourceEnable,
   output reg minusSourceEnable,
   output reg plusSinkEnable,
   output reg minusSinkEnable,
   output reg plusContactEnable,
   output reg minusContactEnable,
   output reg comparatorEnable,
   output reg comparatorOnMinus,
   // id measurement
   output reg idMeasureActive,
   output reg [2:0] idResistorCode,
   output reg idMeasureComplete,
   output reg altIntPulse,
   // io and power
   output reg linePolaritySwap,
   output reg plusLinePullupEnable,
   output reg minusLinePullupEnable,
   output reg [1:0] supplyLevel
);

   // merges a write, set or clear into a register image; reserved bits forced zero
   function [7:0] applyWrite;
      input [7:0] old;
      input [7:0] data;
      input [1:0] op;
      input [7:0] mask;
      begin
         case (op)
            `PVCIO_OP_WR: applyWrite = data & mask;
            `PVCIO_OP_SET: applyWrite = (old | data) & mask;
            `PVCIO_OP_CLR: applyWrite = (old & ~data) & mask;
            default: applyWrite = old & mask;
         endcase
      end
   endfunction

   // three-stage synchroniser with agreement filter on the last two stages
   reg [3:0] syncA_r;
   reg [3:0] syncB_r;
   reg [3:0] syncC_r;
   reg [3:0] syncOut_r;
   wire [3:0] rawIn = {idResistorCodeRaw, dataDetectRaw};

   // a change counts only once the second and third stages agree
   always @(posedge clock) begin
      if (sys_rst) begin
         syncA_r <= 4'h0;
         syncB_r <= 4'h0;
         syncC_r <= 4'h0;
         syncOut_r <= 4'h0;
      end else begin
         syncA_r <= rawIn;
         syncB_r <= syncA_r;
         syncC_r <= syncB_r;
         syncOut_r <= (syncB_r & syncC_r) | (syncOut_r & (syncB_r | syncC_r));
      end
   end

   // bit 0 carries the comparator, the upper bits the converter code
   wire detectSync = syncOut_r[0];
   wire [2:0] idCodeSync = syncOut_r[3:1];

   // register state
   reg [7:0] chgCtrl_r;
   reg [7:0] chgCtrl_nxt;
   reg [7:0] ioCtrl_r;
   reg [7:0] ioCtrl_nxt;
   reg [2:0] idCode_r;
   reg [2:0] idCode_nxt;
   // done is a status flag: hardware sets it, a read clears it
   reg idDone_r;
   reg idDone_nxt;
   reg idStart_r;
   reg idStart_nxt;
   reg idIrqEn_r;
   reg idIrqEn_nxt;

   // access decode
   wire chgHit = (regAddr == `PVCIO_ADDR_CHG);
   wire idWrHit = (regAddr == `PVCIO_ADDR_ID_WR);
   wire idSetHit = (regAddr == `PVCIO_ADDR_ID_SET);
   wire idClrHit = (regAddr == `PVCIO_ADDR_ID_CLR);
   wire ioWrHit = (regAddr == `PVCIO_ADDR_IO_WR);
   wire ioSetHit = (regAddr == `PVCIO_ADDR_IO_SET);
   wire ioClrHit = (regAddr == `PVCIO_ADDR_IO_CLR);
   wire idHit = idWrHit | idSetHit | idClrHit;
   wire ioHit = ioWrHit | ioSetHit | ioClrHit;

   // set and clear aliases pick the merge; the plain alias replaces
   wire [1:0] idOp = idSetHit ? `PVCIO_OP_SET : (idClrHit ? `PVCIO_OP_CLR : `PVCIO_OP_WR);
   wire [1:0] ioOp = ioSetHit ? `PVCIO_OP_SET : (ioClrHit ? `PVCIO_OP_CLR : `PVCIO_OP_WR);

   // comparator status: live, gated by sink enable and an SE0 line state
   wire detectStatus = chgCtrl_r[`PVCIO_CHG_SINK] & detectSync &
      (lineState == `PVCIO_LINE_SE0);

   // register images as software sees them
   wire [7:0] chgImage = {3'h0, detectStatus, chgCtrl_r[3:0]};
   wire [7:0] idImage = {1'b0, idIrqEn_r, 1'b0, idStart_r, idDone_r, idCode_r};
   wire [7:0] idWrVal = applyWrite(idImage, regWrData, idOp, `PVCIO_ID_WMASK);
   wire [7:0] ioWrVal = applyWrite(ioCtrl_r, regWrData, ioOp, `PVCIO_IO_WMASK);

   // a read through any of the three id aliases counts as a read of the code
   wire idWrite = regWrStrobe & idHit;
   wire idRead = regRdStrobe & idHit;

   // launch only from idle; software dropping the start bit aborts a run
   wire measureLaunch = idWrite & idWrVal[`PVCIO_ID_START] & ~idStart_r;
   wire measureAbort = idWrite & ~idWrVal[`PVCIO_ID_START] & idStart_r;
   // timer handshake
   wire measureBusy;
   wire measureFinish;

   // timer only; the measured code arrives through the synchroniser
   pvcio_id_meter #(
      .CYCLES(MEASURE_CYCLES)
   ) meter (
      .clock(clock),
      .sys_rst(sys_rst),
      .launch(measureLaunch),
      .abort(measureAbort),
      .busy(measureBusy),
      .finish(measureFinish)
   );

   // next-state for the charger and io registers
   always @* begin
      chgCtrl_nxt = chgCtrl_r;
      ioCtrl_nxt = ioCtrl_r;
      if (regWrStrobe && chgHit) begin
         chgCtrl_nxt = regWrData & `PVCIO_CHG_WMASK;
      end
      if (regWrStrobe && ioHit) begin
         ioCtrl_nxt = ioWrVal;
      end
   end

   // next-state for the id register; hardware events beat software in the same cycle
   always @* begin
      idCode_nxt = idCode_r;
      idDone_nxt = idDone_r;
      idStart_nxt = idStart_r;
      idIrqEn_nxt = idIrqEn_r;
      if (idWrite) begin
         idCode_nxt = idWrVal[`PVCIO_ID_CODE_HI:`PVCIO_ID_CODE_LO];
         idStart_nxt = idWrVal[`PVCIO_ID_START];
         idIrqEn_nxt = idWrVal[`PVCIO_ID_IRQEN];
      end
      if (idRead) begin
         idDone_nxt = 1'b0;
      end
      if (measureFinish) begin
         idCode_nxt = idCodeSync;
         idDone_nxt = 1'b1;
         idStart_nxt = 1'b0;
      end
   end

   // register update
   always @(posedge clock) begin
      if (sys_rst) begin
         chgCtrl_r <= `PVCIO_CHG_RESET;
         ioCtrl_r <= `PVCIO_IO_RESET;
         idCode_r <= `PVCIO_ID_CODE_RESET;
         idDone_r <= 1'b0;
         idStart_r <= 1'b0;
         idIrqEn_r <= 1'b0;
      end else begin
         chgCtrl_r <= chgCtrl_nxt;
         ioCtrl_r <= ioCtrl_nxt;
         idCode_r <= idCode_nxt;
         idDone_r <= idDone_nxt;
         idStart_r <= idStart_nxt;
         idIrqEn_r <= idIrqEn_nxt;
      end
   end

   // read path: data one cycle after the strobe; unmapped vendor reads give zero
   always @(posedge clock) begin
      if (sys_rst) begin
         regRdData <= `PVCIO_READ_ZERO;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdStrobe;
         if (regRdStrobe) begin
            if (chgHit) begin
               regRdData <= chgImage;
            end else if (idHit) begin
               regRdData <= idImage;
            end else if (ioHit) begin
               regRdData <= ioCtrl_r;
            end else begin
               regRdData <= `PVCIO_READ_ZERO;
            end
         end
      end
   end

   // interrupt on the rising edge of done when either enable is on
   wire irqEnable = idIrqEn_r | carkitIdIrqEnable;
   wire doneRise = idDone_nxt & ~idDone_r;

   always @(posedge clock) begin
      if (sys_rst) begin
         altIntPulse <= 1'b0;
      end else begin
         altIntPulse <= doneRise & irqEnable;
      end
   end

   // charger controls; host mode moves every element to the minus line
   wire hostMode = chgCtrl_r[`PVCIO_CHG_HOST];

   always @(posedge clock) begin
      if (sys_rst) begin
         plusSourceEnable <= 1'b0;
         minusSourceEnable <= 1'b0;
         plusSinkEnable <= 1'b0;
         minusSinkEnable <= 1'b0;
         plusContactEnable <= 1'b0;
         minusContactEnable <= 1'b0;
         comparatorEnable <= 1'b0;
         comparatorOnMinus <= 1'b0;
      end else begin
         plusSourceEnable <= chgCtrl_r[`PVCIO_CHG_SRC] & ~hostMode;
         minusSourceEnable <= chgCtrl_r[`PVCIO_CHG_SRC] & hostMode;
         plusSinkEnable <= chgCtrl_r[`PVCIO_CHG_SINK] & ~hostMode;
         minusSinkEnable <= chgCtrl_r[`PVCIO_CHG_SINK] & hostMode;
         plusContactEnable <= chgCtrl_r[`PVCIO_CHG_CONTACT] & ~hostMode;
         minusContactEnable <= chgCtrl_r[`PVCIO_CHG_CONTACT] & hostMode;
         comparatorEnable <= chgCtrl_r[`PVCIO_CHG_SINK];
         comparatorOnMinus <= hostMode;
      end
   end

   // id status outputs for the carkit side; carkit reads never touch done
   always @(posedge clock) begin
      if (sys_rst) begin
         idMeasureActive <= 1'b0;
         idResistorCode <= `PVCIO_ID_CODE_RESET;
         idMeasureComplete <= 1'b0;
      end else begin
         idMeasureActive <= measureBusy;
         idResistorCode <= idCode_r;
         idMeasureComplete <= idDone_r;
      end
   end

   // io and power; serial level only while serial mode transmits
   wire serialLevelOn = serialModeActive & serialTransmitEnable;

   always @(posedge clock) begin
      if (sys_rst) begin
         linePolaritySwap <= 1'b0;
         plusLinePullupEnable <= 1'b0;
         minusLinePullupEnable <= 1'b0;
         supplyLevel <= 2'h0;
      end else begin
         linePolaritySwap <= ioCtrl_r[`PVCIO_IO_SWAP];
         // pull-ups are needed for idle-high serial lines, so serial mode forces them
         plusLinePullupEnable <= ioCtrl_r[`PVCIO_IO_PUP_PLUS] | serialModeActive;
         minusLinePullupEnable <= ioCtrl_r[`PVCIO_IO_PUP_MINUS] | serialModeActive;
         // only the requested level; the regulator ramps on its own time
         if (serialLevelOn) begin
            supplyLevel <= ioCtrl_r[`PVCIO_IO_UART_HI:`PVCIO_IO_UART_LO];
         end else begin
            supplyLevel <= ioCtrl_r[`PVCIO_IO_USB_HI:`PVCIO_IO_USB_LO];
         end
      end
   end

   // the link is expected to clear charger bits 2:0 before bus traffic
   // and to keep id bit 5 at zero bit 5 is stored as zero regardless
   // a cancelled run never sets done, so it never raises the interrupt

endmodule

/* pvcio_regs_props.sv */
// Purpose: port-level checker for the charger, id and io register group
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound into every pvcio_regs instance
`timescale 1ns/1ns
module pvcio_regs_props #(
   parameter [15:0] MEASURE_CYCLES = 16'h000C
) (
   input wire clock,
   input wire sys_rst,
   input wire [5:0] regAddr,
   input wire regRdStrobe,
   input wire [7:0] regRdData,
   input wire regRdValid,
   input wire serialModeActive,
   input wire plusSinkEnable,
   input wire minusSinkEnable,
   input wire comparatorEnable,
   input wire comparatorOnMinus,
   input wire idMeasureActive,
   input wire idMeasureComplete,
   input wire altIntPulse,
   input wire plusLinePullupEnable,
   input wire minusLinePullupEnable
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   reg [15:0] actCnt_r;
   // length of the current measurement, restarted on each launch
   always @(posedge clock) begin
      if (sys_rst || !idMeasureActive) actCnt_r <= 16'h0000;
      else actCnt_r <= actCnt_r + 16'h0001;
   end
   read_answer_a: assert property (regRdStrobe |=> regRdValid)
      else $error("read strobe not answered next cycle");
   answer_cause_a: assert property (regRdValid |-> $past(regRdStrobe))
      else $error("read valid without a read strobe");
   id_reserved_a: assert property ((regRdStrobe && regAddr >= 6'h36 && regAddr <= 6'h38)
      |=> (regRdData[7] == 1'b0 && regRdData[5] == 1'b0))
      else $error("reserved id bits read nonzero");
   comp_sink_a: assert property (comparatorEnable == (plusSinkEnable | minusSinkEnable))
      else $error("comparator enable not tied to sink enable");
   host_swap_a: assert property (comparatorEnable |-> minusSinkEnable == comparatorOnMinus)
      else $error("sink and comparator on different lines");
   serial_pullup_a: assert property (serialModeActive [*2] |->
      (plusLinePullupEnable && minusLinePullupEnable))
      else $error("pull-ups not forced in serial mode");
   irq_done_a: assert property (altIntPulse |=> idMeasureComplete && !altIntPulse)
      else $error("interrupt pulse without done or too long");
   measure_len_a: assert property ($fell(idMeasureActive) |->
      (actCnt_r + 16'h0001 >= MEASURE_CYCLES && actCnt_r <= MEASURE_CYCLES + 16'h0001))
      else $error("measurement length wrong");
   done_clear_a: assert property ((regRdStrobe && regAddr == 6'h36 && idMeasureComplete &&
      !idMeasureActive) |=> ##1 !idMeasureComplete)
      else $error("done bit not cleared by read");
   cover property (altIntPulse);
   cover property ($fell(idMeasureActive));
   cover property (regRdValid && regRdData[4]);
endmodule
bind pvcio_regs pvcio_regs_props #(.MEASURE_CYCLES(MEASURE_CYCLES)) chk (.clock, .sys_rst,
   .regAddr, .regRdStrobe, .regRdData, .regRdValid, .serialModeActive, .plusSinkEnable,
   .minusSinkEnable, .comparatorEnable, .comparatorOnMinus, .idMeasureActive,
   .idMeasureComplete, .altIntPulse, .plusLinePullupEnable, .minusLinePullupEnable);

/* pvcio_front_model.sv */
// Purpose: behavioural analog front end beside the register group
// Assumes: voltages and measured code chosen by the bench
// Notes: the code lines carry junk while no conversion runs
`timescale 1ns/1ns
module pvcio_front_model (
   input wire comparatorEnable,
   input wire comparatorOnMinus,
   input wire plusVolt,
   input wire minusVolt,
   input wire idMeasureActive,
   input wire [2:0] frontCode,
   output wire dataDetectRaw,
   output wire [2:0] idResistorCodeRaw
);
   // comparator sees the line picked by host mode, dead when disabled
   assign dataDetectRaw = comparatorEnable & (comparatorOnMinus ? minusVolt : plusVolt);
   // inverse code outside a conversion so a stale value cannot pass
   assign idResistorCodeRaw = idMeasureActive ? frontCode : ~frontCode;
endmodule

/* tb.sv */
// Purpose: self-checking bench for the charger, id and io register group
// Assumes: short measurement count for a quick run
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module tb;
   localparam [15:0] MC = 16'h000C;
   reg clock = 1'b0;
   reg sys_rst = 1'b1;
   reg [5:0] regAddr = 6'h00;
   reg [7:0] regWrData = 8'h00;
   reg regWrStrobe = 1'b0;
   reg regRdStrobe = 1'b0;
   reg [1:0] lineState = 2'h1;
   reg serialModeActive = 1'b0;
   reg serialTransmitEnable = 1'b0;
   reg carkitIdIrqEnable = 1'b0;
   reg plusVolt = 1'b0;
   reg minusVolt = 1'b0;
   reg [2:0] frontCode = 3'h0;
   integer fails = 0;
   integer tests_run = 0;
   integer cycles = 0;
   integer i;
   wire [7:0] regRdData;
   wire [2:0] idResistorCodeRaw, idResistorCode;
   wire [1:0] supplyLevel;
   wire regRdValid, dataDetectRaw, plusSourceEnable, minusSourceEnable, plusSinkEnable;
   wire minusSinkEnable, plusContactEnable, minusContactEnable, comparatorEnable;
   wire comparatorOnMinus, idMeasureActive, idMeasureComplete, altIntPulse, linePolaritySwap;
   wire plusLinePullupEnable, minusLinePullupEnable;
   pvcio_regs #(.MEASURE_CYCLES(MC)) uut (.clock, .sys_rst, .regAddr, .regWrData,
      .regWrStrobe, .regRdStrobe, .regRdData, .regRdValid, .dataDetectRaw, .idResistorCodeRaw,
      .lineState, .serialModeActive, .serialTransmitEnable, .carkitIdIrqEnable,
      .plusSourceEnable, .minusSourceEnable, .plusSinkEnable, .minusSinkEnable,
      .plusContactEnable, .minusContactEnable, .comparatorEnable, .comparatorOnMinus,
      .idMeasureActive, .idResistorCode, .idMeasureComplete, .altIntPulse, .linePolaritySwap,
      .plusLinePullupEnable, .minusLinePullupEnable, .supplyLevel);
   pvcio_front_model front (.comparatorEnable, .comparatorOnMinus, .plusVolt, .minusVolt,
      .idMeasureActive, .frontCode, .dataDetectRaw, .idResistorCodeRaw);
   // free-running clock and hang guard
   always #20 clock = ~clock;
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (cycles == 4000) begin
         fails = fails + 1;
         wrap_up;
      end
   end
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   task chk(input string what, input [7:0] exp, input [7:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clock);
         #1;
      end
   endtask
   task wr(input [5:0] a, input [7:0] d);
      begin
         tick(1);
         regAddr = a;
         regWrData = d;
         regWrStrobe = 1'b1;
         tick(1);
         regWrStrobe = 1'b0;
      end
   endtask
   task rd(input [5:0] a, input [7:0] exp);
      begin
         tick(1);
         regAddr = a;
         regRdStrobe = 1'b1;
         tick(1);
         regRdStrobe = 1'b0;
         chk("rdValid", 8'h01, regRdValid);
         chk("rdData", exp, regRdData);
      end
   endtask
   // one measurement: clear, launch, watch the interrupt, read twice
   task meas(input [2:0] c, input [5:0] a, input [7:0] irq, input ck);
      reg seen;
      begin
         frontCode = c;
         carkitIdIrqEnable = ck;
         seen = 1'b0;
         wr(6'h38, 8'h57);
         wr(a, 8'h10 | irq);
         repeat (MC + 12) begin
            tick(1);
            if (altIntPulse === 1'b1) seen = 1'b1;
         end
         chk("irqSeen", {7'h00, irq[6] | ck}, {7'h00, seen});
         chk("idCode", {5'h00, c}, {5'h00, idResistorCode});
         rd(6'h36, {5'h01, c} | irq);
         rd(6'h38, {5'h00, c} | irq);
      end
   endtask
   // main sequence
   initial begin
      tick(16);
      sys_rst = 1'b0;
      rd(6'h32, 8'h00);
      rd(6'h36, 8'h00);
      rd(6'h37, 8'h00);
      rd(6'h39, 8'h04);
      rd(6'h3B, 8'h04);
      rd(6'h30, 8'h00);
      $display("test reset values finished");
      plusVolt = 1'b1;
      minusVolt = 1'b1;
      wr(6'h32, 8'hFF);
      rd(6'h32, 8'h0F);
      chk("minusSource", 8'h01, minusSourceEnable);
      chk("plusSource", 8'h00, plusSourceEnable);
      chk("minusContact", 8'h01, minusContactEnable);
      lineState = 2'h0;
      wr(6'h32, 8'h08);
      tick(5);
      rd(6'h32, 8'h08);
      plusVolt = 1'b0;
      wr(6'h32, 8'h0A);
      tick(5);
      rd(6'h32, 8'h1A);
      plusVolt = 1'b1;
      minusVolt = 1'b0;
      wr(6'h32, 8'h02);
      tick(5);
      rd(6'h32, 8'h12);
      chk("plusSink", 8'h01, plusSinkEnable);
      lineState = 2'h1;
      rd(6'h32, 8'h02);
      wr(6'h32, 8'h05);
      tick(1);
      chk("plusContact", 8'h01, plusContactEnable);
      chk("plusSource", 8'h01, plusSourceEnable);
      chk("minusContact", 8'h00, minusContactEnable);
      wr(6'h32, 8'h00);
      rd(6'h32, 8'h00);
      $display("test charger finished");
      wr(6'h39, 8'hFF);
      rd(6'h3A, 8'hFE);
      chk("swap", 8'h01, linePolaritySwap);
      wr(6'h3B, 8'hC2);
      rd(6'h39, 8'h3C);
      chk("swap", 8'h00, linePolaritySwap);
      wr(6'h3A, 8'h40);
      rd(6'h3B, 8'h7C);
      chk("supply", 8'h01, supplyLevel);
      chk("plusPull", 8'h01, plusLinePullupEnable);
      serialModeActive = 1'b1;
      serialTransmitEnable = 1'b1;
      wr(6'h39, 8'h08);
      tick(2);
      chk("supply", 8'h02, supplyLevel);
      chk("minusPull", 8'h01, minusLinePullupEnable);
      serialTransmitEnable = 1'b0;
      tick(2);
      chk("supply", 8'h00, supplyLevel);
      serialModeActive = 1'b0;
      tick(2);
      chk("plusPull", 8'h00, plusLinePullupEnable);
      $display("test io finished");
      wr(6'h36, 8'h83);
      rd(6'h37, 8'h03);
      for (i = 0; i < 8; i = i + 1) begin
         meas(i[2:0], i[0] ? 6'h37 : 6'h36, i[1] ? 8'h40 : 8'h00, i[2]);
      end
      $display("test id measurement finished");
      wrap_up;
   end
endmodule
